// File: src/rfx_pkg.sv
// constants and types shared by the reflex top, the fault block and the bench
package rfx_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS   = 10;
    localparam int TICK_NS  = 100000;     // parameter time unit, 0.1 ms
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PW      = 16;
    localparam int AW      = 8;
    localparam int DW      = 32;
    localparam int GRP_CH  = 8;
    localparam int NCH     = 16;
    localparam int IRQ_W   = 4;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FUNC  = 8'h00;
    localparam logic [7:0] OFS_TGT   = 8'h04;
    localparam logic [7:0] OFS_VAL1  = 8'h08;
    localparam logic [7:0] OFS_VAL2  = 8'h0C;
    localparam logic [7:0] OFS_GO    = 8'h10;
    localparam logic [7:0] OFS_EXCH  = 8'h14;
    localparam logic [7:0] OFS_IRQST = 8'h18;
    localparam logic [7:0] OFS_IRQMK = 8'h1C;
    localparam logic [7:0] OFS_OUT   = 8'h20;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int TGT_GRP_LSB = 0;
    localparam int TGT_IDX_LSB = 8;
    localparam logic [4:0] GRP_LO = 5'h10;
    localparam logic [4:0] GRP_HI = 5'h18;
    localparam int EXCH_BUSY = 0;
    localparam int EXCH_ERR  = 1;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_REJ   = 1;
    localparam int IRQ_THR   = 2;
    localparam int IRQ_FLT   = 3;
    localparam logic [15:0] FUNC_RST  = 16'h0000;
    localparam logic [15:0] PARAM_RST = 16'h0001;

    typedef enum logic [3:0] {
        FS_IDLE = 4'b0001,
        FS_FAST = 4'b0010,
        FS_HOLD = 4'b0100,
        FS_SLOW = 4'b1000
    } rfx_fstate_t;

endpackage : rfx_pkg

// File: src/rfx_chan_if.sv
// per-channel constants, time base and event between top and function blocks
interface rfx_chan_if #(parameter int PW = 16);
    logic          tick;
    logic          en;
    logic [PW-1:0] p1;
    logic [PW-1:0] p2;
    logic          evt;
    modport ctl (output tick, output en, output p1, output p2, input evt);
    modport blk (input tick, input en, input p1, input p2, output evt);
endinterface : rfx_chan_if

// File: src/rfx_count.sv
// command-counting reflex function of one channel
module rfx_count #(parameter int PW = 16) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // constants and time base
    rfx_chan_if.blk   cfg,
    // field inputs
    input  wire logic cmd_in,
    input  wire logic pulse_in,
    input  wire logic clr_in,
    // outputs
    output logic      phys_out,
    output logic      aux_out
);
    logic [2:0]    in_q_r;
    logic [PW-1:0] cnt_r, cnt_nxt;
    logic          out_r, out_nxt;
    logic          cmd_rise, pulse_rise, clr_rise;

    // inputs low before reset release, so a level high at release is an edge
    assign cmd_rise   = cmd_in & ~in_q_r[0];
    assign pulse_rise = pulse_in & ~in_q_r[1];
    assign clr_rise   = clr_in & ~in_q_r[2];

    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        // saturate rather than wrap back under the threshold
        if (pulse_rise && cnt_r != {PW{1'b1}}) begin
            cnt_nxt = PW'(cnt_r + 1'b1);
        end
        if (clr_rise) begin
            cnt_nxt = '0;
        end
        if (cmd_rise) begin
            out_nxt = 1'b1;
        end
        if (!cmd_in) begin
            out_nxt = 1'b0;
        end
        if (cnt_nxt >= cfg.p1) begin
            out_nxt = 1'b0;
        end
        if (clr_in || !cfg.en) begin
            out_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_q_r <= 3'b000;
            cnt_r  <= '0;
            out_r  <= 1'b0;
        end else begin
            in_q_r <= {clr_in, pulse_in, cmd_in};
            cnt_r  <= cnt_nxt;
            out_r  <= out_nxt;
        end
    end

    assign cfg.evt  = cfg.en & (cnt_nxt >= cfg.p1) & (cnt_r < cfg.p1);
    assign phys_out = out_r;
    assign aux_out  = out_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pulse_inc: assert property (pulse_rise && !clr_rise && cnt_r != {PW{1'b1}}
        |=> cnt_r == PW'($past(cnt_r) + 1'b1)) else $error("count missed an edge");
    a_clr_zero: assert property (clr_rise |=> cnt_r == '0) else $error("counter not zeroed");
    a_cmd_high: assert property (cmd_rise && !clr_in && cfg.en && cnt_nxt < cfg.p1
        |=> phys_out && aux_out) else $error("command edge did not raise output");
    // a threshold lowered under the count by an update is obeyed one cycle later
    a_thr_low: assert property (cnt_r >= cfg.p1 && $stable(cfg.p1) |-> !phys_out && !aux_out)
        else $error("output high at threshold");
    a_cmd_low: assert property (!cmd_in |=> !phys_out) else $error("output high without command");
    a_rst_low: assert property (clr_in |=> !phys_out && !aux_out) else $error("reset did not clear");
endmodule : rfx_count

// File: src/rfx_fault.sv
// fault-signalling reflex function of one channel
module rfx_fault #(parameter int PW = 16) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // constants and time base
    rfx_chan_if.blk   cfg,
    // field inputs
    input  wire logic fault_in,
    input  wire logic ack_in,
    input  wire logic clr_in,
    // outputs
    output logic      phys_out,
    output logic      aux_out
);
    rfx_pkg::rfx_fstate_t st_r, st_nxt;
    logic [1:0]    in_q_r;
    logic [PW-1:0] hc_r, hc_nxt, half;
    logic          blink_r, blink_nxt, out_r, out_nxt, ack_rise, clr_rise;

    assign ack_rise = ack_in & ~in_q_r[0];
    assign clr_rise = clr_in & ~in_q_r[1];
    assign half     = (st_r == rfx_pkg::FS_FAST) ? cfg.p1 : cfg.p2;

    always_comb begin
        st_nxt    = st_r;
        hc_nxt    = hc_r;
        blink_nxt = blink_r;
        unique case (st_r)
            rfx_pkg::FS_IDLE: begin
                if (fault_in) st_nxt = rfx_pkg::FS_FAST;
            end
            rfx_pkg::FS_FAST: begin
                if (ack_rise) st_nxt = fault_in ? rfx_pkg::FS_HOLD : rfx_pkg::FS_SLOW;
            end
            rfx_pkg::FS_HOLD: st_nxt = rfx_pkg::FS_HOLD;
            rfx_pkg::FS_SLOW: st_nxt = rfx_pkg::FS_SLOW;
            default: st_nxt = rfx_pkg::FS_IDLE;
        endcase
        if (clr_rise) begin
            st_nxt = fault_in ? rfx_pkg::FS_FAST : rfx_pkg::FS_IDLE;
        end
        if (!cfg.en) begin
            st_nxt = rfx_pkg::FS_IDLE;
        end
        if (st_nxt != st_r || clr_rise) begin
            hc_nxt    = '0;
            blink_nxt = ~clr_rise; // after a clear the first half is dark
        end else if (cfg.tick) begin
            // equal half periods; a zero time acts as one unit
            if (PW'(hc_r + 1'b1) >= half) begin
                hc_nxt    = '0;
                blink_nxt = ~blink_r;
            end else begin
                hc_nxt = PW'(hc_r + 1'b1);
            end
        end
        unique case (st_nxt)
            rfx_pkg::FS_HOLD: out_nxt = 1'b1;
            rfx_pkg::FS_FAST,
            rfx_pkg::FS_SLOW: out_nxt = blink_nxt;
            default:          out_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r    <= rfx_pkg::FS_IDLE;
            in_q_r  <= 2'b00;
            hc_r    <= '0;
            blink_r <= 1'b0;
            out_r   <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            in_q_r  <= {clr_in, ack_in};
            hc_r    <= hc_nxt;
            blink_r <= blink_nxt;
            out_r   <= out_nxt;
        end
    end

    assign cfg.evt  = (st_nxt == rfx_pkg::FS_FAST) && (st_r != rfx_pkg::FS_FAST);
    assign phys_out = out_r;
    assign aux_out  = 1'b0;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fast_toggle: assert property (st_r == rfx_pkg::FS_FAST && st_nxt == st_r && !clr_rise
        && cfg.tick && PW'(hc_r + 1'b1) >= cfg.p1 |=> phys_out != $past(phys_out))
        else $error("fast flash did not toggle");
    a_ack_hold: assert property (st_r == rfx_pkg::FS_FAST && ack_rise && fault_in && !clr_rise
        && cfg.en |=> phys_out && st_r == rfx_pkg::FS_HOLD) else $error("acknowledged fault not lit");
    a_ack_slow: assert property (st_r == rfx_pkg::FS_FAST && ack_rise && !fault_in && !clr_rise
        && cfg.en |=> st_r == rfx_pkg::FS_SLOW) else $error("slow flash not entered");
    a_clr_low: assert property (clr_rise |=> !phys_out) else $error("clear did not darken output");
    a_restart: assert property (clr_rise && fault_in && cfg.en |=> st_r == rfx_pkg::FS_FAST)
        else $error("fault sequence not restarted");
    a_aux_off: assert property (!aux_out) else $error("aux output active");
    c_slow: cover property (st_r == rfx_pkg::FS_SLOW ##1 clr_rise);
endmodule : rfx_fault

// File: src/rfx_top.sv
// reflex output channels: command counting and fault signalling with parameter update
// ----------------------------------------------------------------
// Overview of operation
// - counter goes to zero on each rising edge of the channel reset input
// - counting: command rising edge raises the physical output
// - counting: each rising pulse edge adds one to the counter
// - counting: threshold reached drops physical and auxiliary outputs
// - counting: command back to zero drops both outputs, threshold or not
// - counting runs regardless of the command level
// - counting: reset input active forces both outputs to zero
// - fault present and unacknowledged: output flashes with period twice fast time
// - acknowledge edge with fault present: output held steadily high
// - acknowledge edge with fault gone: output flashes with period twice slow time
// - clear edge drives the fault output low
// - fault still present after clear: sequence restarts at fast flashing
// - fault function leaves the auxiliary output inactive
// - time values count in units of a tenth of a millisecond
// ----------------------------------------------------------------
//
// Implementation choices: the placing of the registers and strobed register access.
module rfx_top #(
    parameter int TICK_CYCLES = rfx_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RESETN,
    // register port
    input  wire logic [rfx_pkg::AW-1:0]  ADDR,
    input  wire logic [rfx_pkg::DW-1:0]  WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic      [rfx_pkg::DW-1:0]  RDATA,
    // counting inputs
    input  wire logic [rfx_pkg::NCH-1:0] CMD_IN,
    input  wire logic [rfx_pkg::NCH-1:0] PULSE_IN,
    input  wire logic [rfx_pkg::NCH-1:0] CNT_RST_IN,
    // fault inputs
    input  wire logic [rfx_pkg::NCH-1:0] FAULT_IN,
    input  wire logic [rfx_pkg::NCH-1:0] ACK_IN,
    input  wire logic [rfx_pkg::NCH-1:0] CLR_IN,
    // outputs
    output logic      [rfx_pkg::NCH-1:0] PHYS_OUT,
    output logic      [rfx_pkg::NCH-1:0] AUX_OUT,
    output logic                         IRQ
);
    localparam int NCH = rfx_pkg::NCH;
    localparam int PW  = rfx_pkg::PW;
    localparam int DW  = rfx_pkg::DW;
    localparam int TW  = $clog2(TICK_CYCLES + 1);
    localparam int IW  = rfx_pkg::IRQ_W;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    logic [TW-1:0] tcnt_r, tcnt_nxt;
    logic          tick;

    assign tick = (tcnt_r == TW'(TICK_CYCLES - 1));

    always_comb begin
        tcnt_nxt = tick ? '0 : TW'(tcnt_r + 1'b1);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tcnt_r <= '0;
        end else begin
            tcnt_r <= tcnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    logic [NCH-1:0] func_r, func_nxt;
    logic [4:0]     grp_r, grp_nxt;
    logic [2:0]     idx_r, idx_nxt;
    logic [PW-1:0]  val1_r, val1_nxt;
    logic [PW-1:0]  val2_r, val2_nxt;
    logic [DW-1:0]  rdata_r, rdata_nxt;
    logic [IW-1:0]  ist_r, ist_nxt;
    logic [IW-1:0]  imask_r, imask_nxt;
    logic           busy_r, busy_nxt;
    logic           err_r, err_nxt;
    logic [3:0]     dst_r, dst_nxt;
    logic           go, tgt_ok, rej;
    logic [NCH-1:0] thr_evt, flt_evt, out_mux;
    logic [IW-1:0]  ev, w1c;

    assign go     = WR && ADDR == rfx_pkg::OFS_GO;
    // only the two documented groups exist, eight channels each
    assign tgt_ok = (grp_r == rfx_pkg::GRP_LO || grp_r == rfx_pkg::GRP_HI)
                    && 32'(idx_r) < rfx_pkg::GRP_CH;
    // a second request while one is pending is turned away
    assign rej    = go && (busy_r || !tgt_ok);

    always_comb begin
        func_nxt = func_r;
        grp_nxt  = grp_r;
        idx_nxt  = idx_r;
        val1_nxt = val1_r;
        val2_nxt = val2_r;
        if (WR) begin
            unique case (ADDR)
                rfx_pkg::OFS_FUNC: func_nxt = WDATA[NCH-1:0];
                rfx_pkg::OFS_TGT: begin
                    grp_nxt = WDATA[rfx_pkg::TGT_GRP_LSB +: 5];
                    idx_nxt = WDATA[rfx_pkg::TGT_IDX_LSB +: 3];
                end
                rfx_pkg::OFS_VAL1: val1_nxt = WDATA[PW-1:0];
                rfx_pkg::OFS_VAL2: val2_nxt = WDATA[PW-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // parameter update exchange
    // ------------------------------------------------------------
    always_comb begin
        busy_nxt = 1'b0;
        err_nxt  = err_r;
        dst_nxt  = dst_r;
        if (go && !busy_r) begin
            err_nxt = !tgt_ok;
            if (tgt_ok) begin
                busy_nxt = 1'b1;
                dst_nxt  = {grp_r == rfx_pkg::GRP_HI, idx_r};
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb begin
        ev                   = '0;
        ev[rfx_pkg::IRQ_DONE] = busy_r;
        ev[rfx_pkg::IRQ_REJ]  = rej;
        ev[rfx_pkg::IRQ_THR]  = |thr_evt;
        ev[rfx_pkg::IRQ_FLT]  = |flt_evt;
        w1c = (WR && ADDR == rfx_pkg::OFS_IRQST) ? WDATA[IW-1:0] : '0;
        // a new event in the clearing cycle survives
        ist_nxt   = (ist_r & ~w1c) | ev;
        imask_nxt = (WR && ADDR == rfx_pkg::OFS_IRQMK) ? WDATA[IW-1:0] : imask_r;
    end

    assign IRQ = |(ist_r & imask_r);

    // ------------------------------------------------------------
    // read path, data valid the cycle after the strobe only
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = '0;
        if (RD) begin
            unique case (ADDR)
                rfx_pkg::OFS_FUNC:  rdata_nxt = DW'(func_r);
                rfx_pkg::OFS_TGT:   rdata_nxt = DW'({idx_r, 3'b000, grp_r});
                rfx_pkg::OFS_VAL1:  rdata_nxt = DW'(val1_r);
                rfx_pkg::OFS_VAL2:  rdata_nxt = DW'(val2_r);
                rfx_pkg::OFS_EXCH:  rdata_nxt = DW'({err_r, busy_r});
                rfx_pkg::OFS_IRQST: rdata_nxt = DW'(ist_r);
                rfx_pkg::OFS_IRQMK: rdata_nxt = DW'(imask_r);
                rfx_pkg::OFS_OUT:   rdata_nxt = DW'(out_mux);
                default:            rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            func_r  <= rfx_pkg::FUNC_RST;
            grp_r   <= rfx_pkg::GRP_LO;
            idx_r   <= 3'h0;
            val1_r  <= rfx_pkg::PARAM_RST;
            val2_r  <= rfx_pkg::PARAM_RST;
            busy_r  <= 1'b0;
            err_r   <= 1'b0;
            dst_r   <= 4'h0;
            ist_r   <= '0;
            imask_r <= '0;
            rdata_r <= '0;
        end else begin
            func_r  <= func_nxt;
            grp_r   <= grp_nxt;
            idx_r   <= idx_nxt;
            val1_r  <= val1_nxt;
            val2_r  <= val2_nxt;
            busy_r  <= busy_nxt;
            err_r   <= err_nxt;
            dst_r   <= dst_nxt;
            ist_r   <= ist_nxt;
            imask_r <= imask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // ------------------------------------------------------------
    // channels: stored constants and both function blocks
    // ------------------------------------------------------------
    rfx_chan_if #(.PW(PW)) cif_cnt [NCH] ();
    rfx_chan_if #(.PW(PW)) cif_flt [NCH] ();

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [PW-1:0] p1_r, p1_nxt, p2_r, p2_nxt;
        logic          c_phys, c_aux, f_phys, f_aux;

        always_comb begin
            p1_nxt = p1_r;
            p2_nxt = p2_r;
            if (busy_r && dst_r == 4'(i)) begin
                p1_nxt = val1_r;
                p2_nxt = val2_r;
            end
        end

        always_ff @(posedge CLK) begin
            if (!RESETN) begin
                p1_r <= rfx_pkg::PARAM_RST;
                p2_r <= rfx_pkg::PARAM_RST;
            end else begin
                p1_r <= p1_nxt;
                p2_r <= p2_nxt;
            end
        end

        assign cif_cnt[i].tick = tick;
        assign cif_cnt[i].en   = ~func_r[i];
        assign cif_cnt[i].p1   = p1_r;
        assign cif_cnt[i].p2   = p2_r;
        assign cif_flt[i].tick = tick;
        assign cif_flt[i].en   = func_r[i];
        assign cif_flt[i].p1   = p1_r;
        assign cif_flt[i].p2   = p2_r;
        assign thr_evt[i]      = cif_cnt[i].evt;
        assign flt_evt[i]      = cif_flt[i].evt;

        rfx_count #(.PW(PW)) u_cnt (
            .clk      (CLK),
            .rst_n    (RESETN),
            .cfg      (cif_cnt[i]),
            .cmd_in   (CMD_IN[i]),
            .pulse_in (PULSE_IN[i]),
            .clr_in   (CNT_RST_IN[i]),
            .phys_out (c_phys),
            .aux_out  (c_aux)
        );

        rfx_fault #(.PW(PW)) u_flt (
            .clk      (CLK),
            .rst_n    (RESETN),
            .cfg      (cif_flt[i]),
            .fault_in (FAULT_IN[i]),
            .ack_in   (ACK_IN[i]),
            .clr_in   (CLR_IN[i]),
            .phys_out (f_phys),
            .aux_out  (f_aux)
        );

        assign out_mux[i] = func_r[i] ? f_phys : c_phys;
        assign AUX_OUT[i] = func_r[i] ? f_aux : c_aux;
    end

    assign PHYS_OUT = out_mux;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_tick_space: assert property (tick |=> !tick) else $error("time base ticks back to back");
    a_upd_apply: assert property (go && !busy_r && tgt_ok |=> busy_r ##1 !busy_r)
        else $error("update not applied in one cycle");
    a_upd_reject: assert property (go && (busy_r || !tgt_ok) |=> ist_r[rfx_pkg::IRQ_REJ])
        else $error("bad update not flagged");
    a_irq_level: assert property ((ev & imask_r) != '0 && !(WR && ADDR == rfx_pkg::OFS_IRQMK) |=> IRQ)
        else $error("interrupt not raised");
    a_rd_once: assert property (RD |=> RDATA == $past(rdata_nxt) ##1 ($past(RD) || RDATA == '0))
        else $error("read data not framed");

    c_update: cover property (go && tgt_ok ##2 ist_r[rfx_pkg::IRQ_DONE]);
    c_thr: cover property (|thr_evt);
    c_fault: cover property (|flt_evt ##[1:50] |(FAULT_IN & ACK_IN));
    c_irq: cover property (IRQ);
endmodule : rfx_top

// File: verification/rfx_field.sv
// partner model: field pulse source for the counting input
module rfx_field (
    // clock
    input  wire logic       clk,
    // request
    input  wire logic       start,
    input  wire logic [3:0] n,
    // field line
    output logic            pulse,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] left_r;
    initial begin
        pulse  = 1'b0;
        left_r = 5'h00;
    end
    // a low cycle between pulses, so each one is a fresh rising edge
    always @(posedge clk) begin
        if (start) begin
            left_r <= {n, 1'b0};
        end else if (left_r != 5'h00) begin
            left_r <= left_r - 5'h01;
            pulse  <= ~pulse;
        end
    end
    assign busy = (left_r != 5'h00) || pulse;
endmodule : rfx_field

// File: verification/tb.sv
// self-checking bench for the reflex output channels
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [31:0] v;} rfx_exp_t;
    logic        clk, resetn, wr, rd, irq, fld_start, fld_pulse, fld_busy;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, res_v;
    logic [15:0] cmd, pulse_v, cnt_rst, fault, ack, clr, phys, aux;
    logic [3:0]  fld_n;
    rfx_exp_t    q[$];
    event        res_ev;
    int          err_count, n_compared, seed, th, h;
    rfx_top #(.TICK_CYCLES(4)) dut_u (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CMD_IN(cmd), .PULSE_IN(pulse_v | {15'h0000, fld_pulse}),
        .CNT_RST_IN(cnt_rst), .FAULT_IN(fault), .ACK_IN(ack), .CLR_IN(clr), .PHYS_OUT(phys),
        .AUX_OUT(aux), .IRQ(irq));
    rfx_field fld_u (.clk(clk), .start(fld_start), .n(fld_n), .pulse(fld_pulse), .busy(fld_busy));
    // ------------------------------------------------------------
    // bus and result tasks
    // ------------------------------------------------------------
    task automatic note(input string nm, input logic [31:0] v, input logic [31:0] seen);
        q.push_back('{nm, v});
        @(negedge clk);
        res_v = seen;
        -> res_ev;
    endtask : note
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] v, input string nm);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        q.push_back('{nm, v});
        @(negedge clk);
        res_v = rdata;
        -> res_ev;
    endtask : rd_chk
    task automatic pulses(input int n);
        @(posedge clk);
        fld_n     <= 4'(n);
        fld_start <= 1'b1;
        @(posedge clk);
        fld_start <= 1'b0;
        repeat (2) @(posedge clk);
        while (fld_busy) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : pulses
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle
    task automatic hi_count(input int n, input int b);
        h = 0;
        repeat (n) begin
            @(negedge clk);
            h += int'(phys[b]);
        end
    endtask : hi_count
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(res_ev) begin
        `CHK(q[0].nm, q[0].v, res_v)
        void'(q.pop_front());
    end
    initial begin
        #60000;
        err_count++;
        close_out();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 50;
        {resetn, wr, rd, fld_start, addr, wdata, fld_n} = '0;
        {cmd, pulse_v, cnt_rst, fault, ack, clr} = '0;
        th = 2 + ($random(seed) & 3);
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(rfx_pkg::OFS_FUNC, 32'h0000_0000, "func_rst");
        rd_chk(8'h40, 32'h0000_0000, "unmapped");
        wr_reg(rfx_pkg::OFS_IRQMK, 32'h0000_0003);
        wr_reg(rfx_pkg::OFS_TGT, 32'h0000_0010);
        wr_reg(rfx_pkg::OFS_VAL1, 32'(th));
        rd_chk(rfx_pkg::OFS_EXCH, 32'h0000_0000, "exch_idle");
        wr_reg(rfx_pkg::OFS_GO, 32'h0000_0000);
        settle();
        note("irq_done", 32'h0000_0001, 32'(irq));
        wr_reg(rfx_pkg::OFS_IRQST, 32'h0000_0001);
        settle();
        note("irq_clr", 32'h0000_0000, 32'(irq));
        wr_reg(rfx_pkg::OFS_TGT, 32'h0000_0014);
        wr_reg(rfx_pkg::OFS_GO, 32'h0000_0000);
        rd_chk(rfx_pkg::OFS_EXCH, 32'h0000_0002, "exch_bad");
        rd_chk(rfx_pkg::OFS_IRQST, 32'h0000_0002, "irq_rej");
        wr_reg(rfx_pkg::OFS_IRQST, 32'h0000_000F);
        $display("test registers done");
        cmd[0] <= 1'b1;
        settle();
        note("cnt_rise", 32'h0000_0003, 32'({aux[0], phys[0]}));
        rd_chk(rfx_pkg::OFS_OUT, 32'h0000_0001, "out_rd");
        pulses(th - 1);
        note("cnt_below", 32'h0000_0003, 32'({aux[0], phys[0]}));
        pulses(1);
        note("cnt_thr", 32'h0000_0000, 32'({aux[0], phys[0]}));
        cnt_rst[0] <= 1'b1;
        cmd[0] <= 1'b0;
        settle();
        cnt_rst[0] <= 1'b0;
        cmd[0] <= 1'b1;
        settle();
        note("cnt_zeroed", 32'h0000_0001, 32'(phys[0]));
        cmd[0] <= 1'b0;
        settle();
        note("cmd_low", 32'h0000_0000, 32'({aux[0], phys[0]}));
        cmd[0] <= 1'b1;
        settle();
        cnt_rst[0] <= 1'b1;
        settle();
        note("rst_force", 32'h0000_0000, 32'({aux[0], phys[0]}));
        cnt_rst[0] <= 1'b0;
        cmd[0] <= 1'b0;
        pulses(th);
        cmd[0] <= 1'b1;
        settle();
        note("cnt_no_gate", 32'h0000_0000, 32'(phys[0]));
        $display("test counting done");
        wr_reg(rfx_pkg::OFS_FUNC, 32'h0000_0100);
        wr_reg(rfx_pkg::OFS_TGT, 32'h0000_0018);
        wr_reg(rfx_pkg::OFS_VAL1, 32'h0000_0002);
        wr_reg(rfx_pkg::OFS_VAL2, 32'h0000_0003);
        wr_reg(rfx_pkg::OFS_GO, 32'h0000_0000);
        fault[8] <= 1'b1;
        settle();
        hi_count(32, 8);
        note("fast_flash", 32'd16, 32'(h));
        note("aux_idle", 32'h0000_0000, 32'(aux[8]));
        ack[8] <= 1'b1;
        settle();
        hi_count(16, 8);
        note("hold", 32'd16, 32'(h));
        clr[8] <= 1'b1;
        ack[8] <= 1'b0;
        settle();
        clr[8] <= 1'b0;
        hi_count(32, 8);
        note("restart", 32'd16, 32'(h));
        fault[8] <= 1'b0;
        ack[8] <= 1'b1;
        settle();
        hi_count(48, 8);
        note("slow_flash", 32'd24, 32'(h));
        clr[8] <= 1'b1;
        settle();
        hi_count(16, 8);
        note("cleared", 32'd0, 32'(h));
        rd_chk(rfx_pkg::OFS_IRQST, 32'h0000_000D, "irq_events");
        $display("test fault done");
        close_out();
    end
endmodule : tb
